// ### core/tda_pkg.sv
/*
 Constants for the text display attribute engine: byte codes, commands,
 memory map, attribute bit positions, reset values and fill modes.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package tda_pkg;
    // Character and command byte codes.
    localparam logic [7:0] EOL_CODE = 8'h9b;
    localparam logic [7:0] ESC_CODE = 8'h1b;
    localparam logic [7:0] CLR_CODE = 8'h7d;
    localparam logic [7:0] UP_CODE = 8'h1c;
    localparam logic [7:0] CMD_ATTR_LOW = 8'hf4;
    localparam logic [7:0] CMD_ATTR_HIGH = 8'hf5;
    localparam logic [7:0] CMD_MASTER_RST = 8'hc2;
    localparam logic [7:0] CMD_LIST_OFF = 8'hd0;
    localparam logic [7:0] CMD_LIST_ON = 8'hd1;
    localparam logic [7:0] CMD_SET_STD = 8'hd4;
    localparam logic [7:0] CMD_SET_INTL = 8'hd5;
    localparam logic [7:0] CMD_SET_INT = 8'hd6;
    localparam logic [7:0] CMD_REV_OFF = 8'hde;
    localparam logic [7:0] CMD_REV_ON = 8'hdf;
    // Reset values.
    localparam logic [7:0] ATTR_RESET = 8'hff;
    localparam logic [7:0] LEFT_RESET = 8'h00;
    localparam logic [7:0] RIGHT_RESET = 8'h4f;
    // Rows and memory map.
    localparam int ROWS = 25;
    localparam logic [4:0] LAST_TEXT_ROW = 5'h17;
    localparam logic [4:0] STATUS_ROW = 5'h18;
    localparam logic [12:0] MEM_FIRST = 13'h0000;
    localparam logic [12:0] MEM_LAST = 13'h1fff;
    localparam logic [12:0] TEXT_LAST = 13'h19ff;
    localparam logic [12:0] TAB_BASE = 13'h1a00;
    localparam logic [12:0] TAB_END = 13'h1aff;
    localparam logic [2:0] TAB_PHASE = 3'h7;
    localparam logic [7:0] TAB_EXTRA = 8'h02;
    localparam logic [7:0] TAB_SET = 8'h01;
    // Row pointer byte fields.
    localparam int PTR_SET = 5;
    localparam int PTR_BYPASS = 6;
    // Attribute bit positions, all active low.
    localparam int ATTR_REV = 0;
    localparam int ATTR_BLINK = 2;
    localparam int ATTR_DH = 3;
    localparam int ATTR_DW = 4;
    localparam int ATTR_UL = 5;
    localparam int ATTR_BLANK = 6;
    localparam int ATTR_BLOCK = 7;
    // Blink toggles every 32 frames; glyph height at 60 Hz.
    localparam logic [4:0] BLINK_LAST = 5'h1f;
    localparam int CELL_LINES = 10;
    typedef enum {FILL_IDLE, FILL_INIT, FILL_EOL} tda_fill_t;
endpackage

// ### core/tda_engine.sv
/*
 Text display attribute engine: host word decoding, cursor, video memory,
 row pointers, attribute latches and the per-cell pixel pipeline.
 Assumes the serial link is already deframed into 9-bit words and that an
 external glyph generator answers glyphCode/glyphLine in the same cycle.
*/
`timescale 1ns/100ps
module tda_engine
    import tda_pkg::*;
#(
    parameter int LINES = CELL_LINES
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic hostValid,
    input wire logic [8:0] hostWord,
    output logic hostReady,
    input wire logic reverseBlinkField,
    input wire logic frameStart,
    input wire logic cellReq,
    input wire logic [4:0] cellRow,
    input wire logic [7:0] cellCol,
    input wire logic [3:0] cellLine,
    output logic [7:0] glyphCode,
    output logic [3:0] glyphLine,
    output logic glyphSetSel,
    output logic glyphExternal,
    input wire logic [7:0] glyphBits,
    output logic pixelValid,
    output logic [7:0] pixelBits,
    output logic [4:0] cursorRow,
    output logic [7:0] cursorCol,
    output logic listMode
);
    logic [7:0] vidMem [0:8191];
    logic [7:0] rowPtrQ [0:ROWS-1];
    logic [7:0] latchLowQ, latchHighQ, lastCharQ, leftQ, rightQ, colQ;
    logic [4:0] rowQ, frameCntQ;
    logic escQ, listQ, extQ, intlQ, grevQ, blinkQ;
    tda_fill_t fillQ;
    logic [12:0] fillAddrQ, fillLastQ;
    logic fillSkipQ;
    logic [7:0] s1CodeQ, s1AttrQ;
    logic [3:0] s1LineQ, s1RawLineQ;
    logic s1ValidQ, s1ExtQ, s1SetQ, s1BlockQ, s1DhQ;
    logic dwPendQ;
    logic [7:0] dwRightQ, pixQ;
    logic pixValidQ;

    logic take, isChr, isCmd, lit, inStatus, atRight;
    logic doEsc, doClr, doUp, doEol, doPrint, newLine, scrollEv, masterRst;
    logic [7:0] b;
    logic memWe;
    logic [12:0] memWrAddr;
    logic [7:0] memWrData;

    function automatic logic [7:0] initByte(input logic [12:0] a);
        // Tab flags: column mod 8 == 7, plus the extra stop.
        if (a >= TAB_BASE && a <= TAB_END) begin
            initByte = (a[2:0] == TAB_PHASE || a[7:0] == TAB_EXTRA) ? TAB_SET : 8'h00;
        end else begin
            initByte = EOL_CODE;
        end
    endfunction

    function automatic logic [7:0] blockRow(input logic [7:0] c, input logic [3:0] ln);
        logic [2:0] s;
        s = 3'h0;
        // Top row 0,1,0; middle 2,3,4; bottom 5,6,5.
        if (32'(ln) * 3 < LINES) begin
            s = {c[0], c[1], c[0]};
        end else if (32'(ln) * 3 < 2 * LINES) begin
            s = {c[2], c[3], c[4]};
        end else begin
            s = {c[5], c[6], c[5]};
        end
        blockRow = {{3{s[2]}}, {3{s[1]}}, {2{s[0]}}};
    endfunction

    function automatic logic [7:0] applyFx(input logic [7:0] g, input logic [7:0] at,
                                           input logic dh, input logic [3:0] ln,
                                           input logic ph, input logic rbf, input logic grev);
        logic [7:0] r;
        logic inv;
        r = g;
        inv = 1'b0;
        if (!at[ATTR_BLANK] && !dh) begin
            r = 8'h00;
        end
        if (!at[ATTR_BLINK] && ph) begin
            if (!at[ATTR_REV] && rbf) begin
                inv = 1'b1;
            end else begin
                r = 8'h00;
            end
        end
        if (!at[ATTR_UL] && 32'(ln) == LINES - 1) begin
            r = 8'hff;
        end
        if (inv) begin
            r = ~r;
        end
        if (!at[ATTR_REV]) begin
            r = ~r;
        end
        if (grev) begin
            r = ~r;
        end
        applyFx = r;
    endfunction

    assign hostReady = (fillQ == FILL_IDLE);
    assign take = hostValid && hostReady;
    assign isCmd = take && hostWord[8];
    assign isChr = take && !hostWord[8];
    assign b = hostWord[7:0];
    assign inStatus = (rowQ == STATUS_ROW);
    assign atRight = (colQ == rightQ);
    // In list mode everything but the line end prints literally.
    assign lit = escQ || (listQ && b != EOL_CODE);
    assign doEsc = isChr && !lit && b == ESC_CODE;
    assign doClr = isChr && !lit && b == CLR_CODE;
    assign doUp = isChr && !lit && !inStatus && b == UP_CODE;
    assign doEol = isChr && !lit && !inStatus && b == EOL_CODE;
    assign doPrint = isChr && !doEsc && !doClr && !doUp && !doEol;
    assign newLine = doEol || (doPrint && atRight && !inStatus);
    assign scrollEv = newLine && rowQ == LAST_TEXT_ROW;
    assign masterRst = isCmd && b == CMD_MASTER_RST;

    always_comb begin
        memWe = 1'b0;
        memWrAddr = {rowPtrQ[rowQ][4:0], colQ};
        memWrData = b;
        if (fillQ != FILL_IDLE) begin
            memWe = !(fillSkipQ && fillAddrQ[12:8] == rowPtrQ[STATUS_ROW][4:0]);
            memWrAddr = fillAddrQ;
            memWrData = (fillQ == FILL_INIT) ? initByte(fillAddrQ) : EOL_CODE;
        end else if (doEol) begin
            memWe = 1'b1;
            memWrAddr = {rowPtrQ[rowQ][4:0], rightQ};
            memWrData = EOL_CODE;
        end else if (doPrint) begin
            memWe = 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (memWe) begin
            vidMem[memWrAddr] <= memWrData;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            fillQ <= FILL_INIT;
            fillAddrQ <= MEM_FIRST;
            fillLastQ <= MEM_LAST;
            fillSkipQ <= 1'b0;
        end else if (masterRst) begin
            fillQ <= FILL_INIT;
            fillAddrQ <= MEM_FIRST;
            fillLastQ <= MEM_LAST;
            fillSkipQ <= 1'b0;
        end else if (fillQ != FILL_IDLE) begin
            fillAddrQ <= fillAddrQ + 13'h0001;
            if (fillAddrQ == fillLastQ) begin
                fillQ <= FILL_IDLE;
            end
        end else if (doClr && inStatus) begin
            fillQ <= FILL_EOL;
            fillAddrQ <= {rowPtrQ[STATUS_ROW][4:0], 8'h00};
            fillLastQ <= {rowPtrQ[STATUS_ROW][4:0], 8'hff};
            fillSkipQ <= 1'b0;
        end else if (doClr) begin
            // The status row keeps its text across a screen clear.
            fillQ <= FILL_EOL;
            fillAddrQ <= MEM_FIRST;
            fillLastQ <= TEXT_LAST;
            fillSkipQ <= 1'b1;
        end else if (scrollEv) begin
            // The row rotated to the bottom comes back empty.
            fillQ <= FILL_EOL;
            fillAddrQ <= {rowPtrQ[0][4:0], 8'h00};
            fillLastQ <= {rowPtrQ[0][4:0], 8'hff};
            fillSkipQ <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < ROWS; i++) begin
                rowPtrQ[i] <= 8'(i);
            end
        end else if (masterRst) begin
            for (int i = 0; i < ROWS; i++) begin
                rowPtrQ[i] <= 8'(i);
            end
        end else if (scrollEv) begin
            for (int i = 0; i < ROWS - 2; i++) begin
                rowPtrQ[i] <= rowPtrQ[i+1];
            end
            rowPtrQ[LAST_TEXT_ROW] <= rowPtrQ[0];
        end
    end

    // Cursor, escape and margins.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rowQ <= 5'h00;
            colQ <= LEFT_RESET;
            escQ <= 1'b0;
            leftQ <= LEFT_RESET;
            rightQ <= RIGHT_RESET;
        end else if (masterRst) begin
            rowQ <= 5'h00;
            colQ <= LEFT_RESET;
            escQ <= 1'b0;
            leftQ <= LEFT_RESET;
            rightQ <= RIGHT_RESET;
        end else if (isChr) begin
            escQ <= doEsc;
            if (doClr) begin
                colQ <= leftQ;
                if (!inStatus) begin
                    rowQ <= 5'h00;
                end
            end else if (doUp) begin
                rowQ <= (rowQ == 5'h00) ? LAST_TEXT_ROW : rowQ - 5'h01;
            end else if (doEol || (doPrint && atRight)) begin
                colQ <= leftQ;
                if (newLine && rowQ != LAST_TEXT_ROW) begin
                    rowQ <= rowQ + 5'h01;
                end
            end else if (doPrint) begin
                colQ <= colQ + 8'h01;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            latchLowQ <= ATTR_RESET;
            latchHighQ <= ATTR_RESET;
            lastCharQ <= 8'h00;
        end else if (masterRst) begin
            latchLowQ <= ATTR_RESET;
            latchHighQ <= ATTR_RESET;
        end else if (isChr) begin
            lastCharQ <= b;
        end else if (isCmd && b == CMD_ATTR_LOW) begin
            latchLowQ <= lastCharQ;
        end else if (isCmd && b == CMD_ATTR_HIGH) begin
            latchHighQ <= lastCharQ;
        end
    end

    // Mode flags from commands.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            listQ <= 1'b0;
            extQ <= 1'b1;
            intlQ <= 1'b0;
            grevQ <= 1'b0;
        end else if (masterRst) begin
            listQ <= 1'b0;
            extQ <= 1'b1;
            intlQ <= 1'b0;
            grevQ <= 1'b0;
        end else if (isCmd) begin
            case (b)
                CMD_LIST_OFF: listQ <= 1'b0;
                CMD_LIST_ON: listQ <= 1'b1;
                CMD_SET_STD: begin
                    extQ <= 1'b1;
                    intlQ <= 1'b0;
                end
                CMD_SET_INTL: begin
                    extQ <= 1'b1;
                    intlQ <= 1'b1;
                end
                CMD_SET_INT: extQ <= 1'b0;
                CMD_REV_OFF: grevQ <= 1'b0;
                CMD_REV_ON: grevQ <= 1'b1;
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            frameCntQ <= 5'h00;
            blinkQ <= 1'b0;
        end else if (frameStart) begin
            frameCntQ <= frameCntQ + 5'h01;
            if (frameCntQ == BLINK_LAST) begin
                blinkQ <= !blinkQ;
            end
        end
    end

    // Stage one: fetch the cell and choose its latch.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        logic [7:0] p, c, at;
        logic ext, blk, dh;
        logic [4:0] ln;
        if (!rst_b) begin
            s1ValidQ <= 1'b0;
            s1CodeQ <= 8'h00;
            s1AttrQ <= ATTR_RESET;
            s1LineQ <= 4'h0;
            s1RawLineQ <= 4'h0;
            s1ExtQ <= 1'b0;
            s1SetQ <= 1'b0;
            s1BlockQ <= 1'b0;
            s1DhQ <= 1'b0;
        end else begin
            p = rowPtrQ[cellRow];
            c = vidMem[{p[4:0], cellCol}];
            ext = extQ && !p[PTR_BYPASS];
            at = ((ext ? (c[7] && c != EOL_CODE) : c[7])) ? latchHighQ : latchLowQ;
            blk = !at[ATTR_BLOCK];
            dh = !at[ATTR_DH] && (!ext || blk);
            ln = at[ATTR_BLANK] ? 5'(cellLine) : 5'(cellLine) + 5'(LINES);
            s1ValidQ <= cellReq;
            s1CodeQ <= c;
            s1AttrQ <= at;
            s1LineQ <= dh ? ln[4:1] : cellLine;
            s1RawLineQ <= cellLine;
            s1ExtQ <= ext;
            s1SetQ <= p[PTR_SET] | intlQ;
            s1BlockQ <= blk;
            s1DhQ <= dh;
        end
    end

    // Stage two: apply the attribute effects.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        logic [7:0] g;
        logic [15:0] wide;
        if (!rst_b) begin
            pixValidQ <= 1'b0;
            pixQ <= 8'h00;
            dwPendQ <= 1'b0;
            dwRightQ <= 8'h00;
        end else begin
            pixValidQ <= s1ValidQ;
            g = glyphBits;
            if (s1ExtQ && s1CodeQ[7]) begin
                g = (s1CodeQ == EOL_CODE) ? 8'h00 : ~glyphBits;
            end
            if (s1BlockQ) begin
                g = blockRow(s1CodeQ, s1LineQ);
            end
            for (int i = 0; i < 8; i++) begin
                wide[2*i] = g[i];
                wide[2*i+1] = g[i];
            end
            if (s1ValidQ) begin
                // second cell shows the right half
                if (dwPendQ) begin
                    pixQ <= dwRightQ;
                    dwPendQ <= 1'b0;
                end else if (!s1AttrQ[ATTR_DW]) begin
                    pixQ <= applyFx(wide[15:8], s1AttrQ, s1DhQ, s1RawLineQ, blinkQ, reverseBlinkField, grevQ);
                    dwRightQ <= applyFx(wide[7:0], s1AttrQ, s1DhQ, s1RawLineQ, blinkQ, reverseBlinkField, grevQ);
                    dwPendQ <= 1'b1;
                end else begin
                    pixQ <= applyFx(g, s1AttrQ, s1DhQ, s1RawLineQ, blinkQ, reverseBlinkField, grevQ);
                end
            end
        end
    end

    assign glyphCode = s1CodeQ;
    assign glyphLine = s1LineQ;
    assign glyphSetSel = s1SetQ;
    // internal set shows code as is
    assign glyphExternal = s1ExtQ;
    assign pixelBits = pixQ;
    assign pixelValid = pixValidQ;
    assign cursorRow = rowQ;
    assign cursorCol = colQ;
    assign listMode = listQ;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    sequence s_loadLow;
        isCmd && b == CMD_ATTR_LOW;
    endsequence
    sequence s_eolStart;
        cellReq && extQ && !rowPtrQ[cellRow][PTR_BYPASS] && vidMem[{rowPtrQ[cellRow][4:0], cellCol}] == EOL_CODE;
    endsequence
    property p_upWrap;
        doUp && rowQ == 5'h00 |=> rowQ == LAST_TEXT_ROW;
    endproperty
    a_upWrap: assert property (p_upWrap) else $error("move up did not wrap");
    property p_statusWrap;
        doPrint && inStatus && atRight |=> rowQ == STATUS_ROW && colQ == $past(leftQ);
    endproperty
    a_statusWrap: assert property (p_statusWrap) else $error("status row wrap wrong");
    property p_latchLoad;
        s_loadLow |=> latchLowQ == $past(lastCharQ) ##1 latchLowQ == $past(lastCharQ, 2);
    endproperty
    a_latchLoad: assert property (p_latchLoad) else $error("latch load wrong");
    property p_latchHold;
        !(isCmd && (b == CMD_ATTR_HIGH || b == CMD_MASTER_RST)) |=> $stable(latchHighQ);
    endproperty
    a_latchHold: assert property (p_latchHold) else $error("latch changed");
    property p_ptrHold;
        !scrollEv && !masterRst |=> $stable(rowPtrQ[0]) && $stable(rowPtrQ[LAST_TEXT_ROW]);
    endproperty
    a_ptrHold: assert property (p_ptrHold) else $error("row pointer moved");
    property p_eolMargin;
        doEol |-> memWe && memWrAddr[7:0] == rightQ && memWrData == EOL_CODE;
    endproperty
    a_eolMargin: assert property (p_eolMargin) else $error("line end misplaced");
    property p_blink;
        frameStart && frameCntQ != BLINK_LAST |=> $stable(blinkQ);
    endproperty
    a_blink: assert property (p_blink) else $error("blink toggled early");
    property p_reset;
        masterRst |=> latchLowQ == ATTR_RESET && fillQ == FILL_INIT && rightQ == RIGHT_RESET && !hostReady;
    endproperty
    a_reset: assert property (p_reset) else $error("master reset incomplete");
    property p_eolLatch;
        s_eolStart |=> s1AttrQ == $past(latchLowQ);
    endproperty
    a_eolLatch: assert property (p_eolLatch) else $error("line end used high latch");
endmodule

// ### bench/tda_host_model.sv
/*
 Host side model: hands deframed words to the engine one at a time.
 Assumes hostReady only changes just after a rising clock edge.
*/
`timescale 1ns/100ps
module tda_host_model
    import tda_pkg::*;
(
    input wire logic clk_sys,
    input wire logic hostReady,
    output logic hostValid,
    output logic [8:0] hostWord
);
    logic readyLate;
    initial begin
        hostValid = 1'b0;
        hostWord = 9'h000;
    end
    // Ready is stable between edges, so the value at the falling edge is the one seen at the next rising edge.
    always @(negedge clk_sys) begin
        readyLate = hostReady;
    end
    task automatic send(input logic [8:0] w);
        @(posedge clk_sys);
        hostValid <= 1'b1;
        hostWord <= w;
        do @(posedge clk_sys); while (readyLate !== 1'b1);
        hostValid <= 1'b0;
        hostWord <= ~w;
    endtask
    task automatic load_attr(input logic [7:0] a, input logic hi);
        send({1'b0, a});
        send({1'b1, hi ? CMD_ATTR_HIGH : CMD_ATTR_LOW});
    endtask
endmodule

// ### bench/testbench.sv
/*
 Self-checking bench for the attribute engine with a host model and a glyph generator.
 Assumes the default cell height and a generator that answers in the same cycle.
*/
`timescale 1ns/100ps
module testbench;
    import tda_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_b, frameStart, rbf, cellReq, hostValid, hostReady, pixelValid, glyphSetSel, glyphExternal, listMode;
    logic [8:0] hostWord;
    logic [4:0] cellRow, cursorRow;
    logic [7:0] cellCol, glyphCode, glyphBits, pixelBits, cursorCol;
    logic [3:0] cellLine, glyphLine;
    int failures, compares, cycles, seed, col, latLo, latHi, gRev;
    int row0[256];
    int ext = 1, intl = 0, dwMode = 0;
    int attrs[5] = '{'hff, 'hfd, 'hdf, 'hbf, 'hbe};
    always #5 clk_sys = ~clk_sys;
    assign glyphBits = {1'b0, glyphCode[6:0]} ^ {glyphLine, 4'h5};
    tda_host_model host (.clk_sys(clk_sys), .hostReady(hostReady), .hostValid(hostValid), .hostWord(hostWord));
    tda_engine u_dut (.clk_sys(clk_sys), .rst_b(rst_b), .hostValid(hostValid), .hostWord(hostWord),
        .hostReady(hostReady), .reverseBlinkField(rbf), .frameStart(frameStart), .cellReq(cellReq),
        .cellRow(cellRow), .cellCol(cellCol), .cellLine(cellLine), .glyphCode(glyphCode),
        .glyphLine(glyphLine), .glyphSetSel(glyphSetSel), .glyphExternal(glyphExternal),
        .glyphBits(glyphBits), .pixelValid(pixelValid), .pixelBits(pixelBits), .cursorRow(cursorRow),
        .cursorCol(cursorCol), .listMode(listMode));
    task automatic end_of_test;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cycles++;
        frameStart <= (cycles % 16) == 0;
        if (cycles == 60000) begin
            failures++;
            end_of_test;
        end
    end
    task automatic check(input string n, input logic [8:0] e, input logic [8:0] s);
        compares++;
        if (s !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    function automatic logic [7:0] exp_pix(input int c, input int l);
        logic [7:0] g;
        logic [7:0] a;
        g = {1'b0, c[6:0]} ^ {l[3:0], 4'h5};
        a = (c[7] && (c != 'h9b || ext == 0)) ? latHi[7:0] : latLo[7:0];
        if (ext != 0 && c >= 'h80) g = ~g;
        if (ext != 0 && c == 'h9b) g = 8'h00;
        // A double-width cell shows each source pixel twice, left half first.
        if (dwMode == 1) g = {{2{g[7]}}, {2{g[6]}}, {2{g[5]}}, {2{g[4]}}};
        if (dwMode == 2) g = {{2{g[3]}}, {2{g[2]}}, {2{g[1]}}, {2{g[0]}}};
        if (!a[ATTR_BLANK]) g = 8'h00;
        if (!a[ATTR_UL] && l == CELL_LINES - 1) g = 8'hff;
        if (!a[ATTR_REV]) g = ~g;
        if (gRev != 0) g = ~g;
        return g;
    endfunction
    task automatic pix(input int c, input int l);
        int s;
        // The cell after a double-width one shows the right half of its left neighbour.
        s = (dwMode == 2) ? c - 1 : c;
        @(posedge clk_sys);
        cellReq <= 1'b1;
        cellCol <= c[7:0];
        cellLine <= l[3:0];
        @(posedge clk_sys);
        cellReq <= 1'b0;
        #1;
        check("glyphCode", 9'(row0[c]), {1'b0, glyphCode});
        check("glyphLine", 9'(l), {5'h00, glyphLine});
        check("glyphExternal", 9'(ext), {8'h00, glyphExternal});
        check("glyphSetSel", 9'(intl), {8'h00, glyphSetSel});
        @(posedge clk_sys);
        #1;
        check("pixelValid", 9'h001, {8'h00, pixelValid});
        check("pixelBits", {1'b0, exp_pix(row0[s], l)}, {1'b0, pixelBits});
    endtask
    task automatic cur(input int r, input int c);
        @(posedge clk_sys);
        #1;
        check("cursorRow", 9'(r), {4'h0, cursorRow});
        check("cursorCol", 9'(c), {1'b0, cursorCol});
    endtask
    task automatic put(input int c);
        host.send({1'b0, c[7:0]});
        row0[col] = c;
        col++;
        cur(0, col);
    endtask
    task automatic attr(input int a);
        host.load_attr(a[7:0], 1'b0);
        row0[col] = a;
        col++;
        latLo = a;
        cur(0, col);
    endtask
    task automatic wait_fill(input int len);
        int n;
        n = 0;
        #1;
        while (hostReady !== 1'b1 && n < 9000) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        check("fillLength", 9'h001, 9'(n > len - 8 && n < len + 8));
    endtask
    initial begin
        seed = 85;
        rst_b = 1'b0;
        rbf = 1'b0;
        cellReq = 1'b0;
        cellRow = 5'h00;
        cellCol = 8'h00;
        cellLine = 4'h0;
        latLo = 'hff;
        latHi = 'hff;
        foreach (row0[i]) row0[i] = 'h9b;
        repeat (10) @(posedge clk_sys);
        check("listMode", 9'h000, {8'h00, listMode});
        cur(0, 0);
        @(posedge clk_sys);
        rst_b <= 1'b1;
        wait_fill(8192);
        $display("end test reset");
        put('hfe);
        attr('hfe);
        put('h41);
        pix(0, 0);
        pix(1, 0);
        pix(4, 0);
        pix(5, 0);
        foreach (attrs[i]) begin
            attr(attrs[i]);
            pix(1, 9);
            pix(1, 3);
        end
        attr('hef);
        dwMode = 1;
        pix(2, 3);
        dwMode = 2;
        pix(3, 3);
        dwMode = 0;
        repeat (6) begin
            attr(($random(seed) | 'h9c) & 'hff);
            pix(1, 9);
            pix(col - 1, 2);
        end
        host.send({1'b1, CMD_REV_ON});
        gRev = 1;
        pix(1, 9);
        host.send({1'b1, CMD_REV_OFF});
        gRev = 0;
        pix(0, 5);
        $display("end test attributes");
        host.send({1'b1, CMD_SET_INTL});
        intl = 1;
        pix(0, 4);
        host.send({1'b1, CMD_SET_INT});
        ext = 0;
        pix(0, 4);
        pix(100, 7);
        host.send({1'b1, CMD_SET_STD});
        ext = 1;
        intl = 0;
        pix(100, 7);
        $display("end test character sets");
        host.send({1'b0, UP_CODE});
        cur(23, col);
        host.send({1'b0, EOL_CODE});
        wait_fill(256);
        cur(23, 0);
        host.send({1'b0, UP_CODE});
        cur(22, 0);
        host.send({1'b1, CMD_LIST_ON});
        cur(22, 0);
        check("listMode", 9'h001, {8'h00, listMode});
        host.send({1'b1, CMD_LIST_OFF});
        cur(22, 0);
        check("listMode", 9'h000, {8'h00, listMode});
        $display("end test cursor");
        host.send({1'b1, CMD_MASTER_RST});
        wait_fill(8192);
        cur(0, 0);
        foreach (row0[i]) row0[i] = 'h9b;
        latLo = 'hff;
        pix(1, 9);
        $display("end test master reset");
        end_of_test;
    end
endmodule
